// ---- gpiop_board.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// board side of the pads: resolves drive, external sources, pulls and float
module gpiop_board (
	input  wire logic       pclk,
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pu,
	input  wire logic [7:0] pin_pd,
	input  wire logic [7:0] ext_v,
	input  wire logic [7:0] ext_en,
	output logic      [7:0] pad
);
	logic [7:0] flt = 8'hA5;

	// undriven pad wanders every cycle
	always @(posedge pclk) begin
		flt <= ~flt;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) pad[i] = pin_o[i];
			else if (ext_en[i]) pad[i] = ext_v[i];
			else if (pin_pu[i]) pad[i] = 1'b1;
			else if (pin_pd[i]) pad[i] = 1'b0;
			else pad[i] = flt[i];
		end
	end
endmodule // gpiop_board
`default_nettype wire

// ---- gpiop_pkg.sv ----
`default_nettype none
package gpiop_pkg;
	localparam int GPIOP_PINS = 8;
	localparam int GPIOP_AW   = 12;

	localparam logic [11:0] GPIOP_DIR      = 12'h000;
	localparam logic [11:0] GPIOP_DIRSET   = 12'h004;
	localparam logic [11:0] GPIOP_DIRCLR   = 12'h008;
	localparam logic [11:0] GPIOP_DIRTGL   = 12'h00C;
	localparam logic [11:0] GPIOP_OUT      = 12'h010;
	localparam logic [11:0] GPIOP_OUTSET   = 12'h014;
	localparam logic [11:0] GPIOP_OUTCLR   = 12'h018;
	localparam logic [11:0] GPIOP_OUTTGL   = 12'h01C;
	localparam logic [11:0] GPIOP_IN       = 12'h020;
	localparam logic [11:0] GPIOP_MASK0    = 12'h024;
	localparam logic [11:0] GPIOP_MASK1    = 12'h028;
	localparam logic [11:0] GPIOP_FLAGS    = 12'h02C;
	localparam logic [11:0] GPIOP_FLAGCLR  = 12'h030;
	localparam logic [11:0] GPIOP_INTEN    = 12'h034;
	localparam logic [11:0] GPIOP_MULTISEL = 12'h038;
	localparam logic [11:0] GPIOP_MULTICFG = 12'h03C;
	localparam logic [11:0] GPIOP_REMAP    = 12'h040;
	localparam logic [11:0] GPIOP_OUTCTL   = 12'h044;
	localparam logic [11:0] GPIOP_WAKECTL  = 12'h048;
	localparam logic [11:0] GPIOP_PINCFG0  = 12'h060;
	localparam logic [11:0] GPIOP_PINCFG7  = 12'h07C;

	// pin configuration fields
	localparam int GPIOP_SENSE_LSB = 0;
	localparam int GPIOP_DRIVE_LSB = 3;
	localparam int GPIOP_INV_BIT   = 6;
	localparam int GPIOP_SLEW_BIT  = 7;

	localparam logic [2:0] GPIOP_SN_BOTH = 3'h0;
	localparam logic [2:0] GPIOP_SN_RISE = 3'h1;
	localparam logic [2:0] GPIOP_SN_FALL = 3'h2;
	localparam logic [2:0] GPIOP_SN_LOW  = 3'h3;

	localparam logic [2:0] GPIOP_DR_TOTEM  = 3'h0;
	localparam logic [2:0] GPIOP_DR_KEEP   = 3'h1;
	localparam logic [2:0] GPIOP_DR_PULLDN = 3'h2;
	localparam logic [2:0] GPIOP_DR_PULLUP = 3'h3;
	localparam logic [2:0] GPIOP_DR_WOR    = 3'h4;
	localparam logic [2:0] GPIOP_DR_WAND   = 3'h5;
	localparam logic [2:0] GPIOP_DR_WOR_PD = 3'h6;
	localparam logic [2:0] GPIOP_DR_WAND_PU = 3'h7;

	// output control fields and fixed pins
	localparam int GPIOP_CLKOUT_BIT = 0;
	localparam int GPIOP_RTCOUT_BIT = 1;
	localparam int GPIOP_EVOUT_BIT  = 2;
	localparam int GPIOP_EVSEL_LSB  = 3;
	localparam int GPIOP_CLK_PIN    = 7;
	localparam int GPIOP_RTC_PIN    = 6;
	localparam int GPIOP_EV_PIN     = 5;

	// remap groups: timer, serial, spi lanes; remap swaps nibbles
	localparam logic [2:0][7:0] GPIOP_GRP = {8'hF0, 8'h0C, 8'h03};

	localparam logic [7:0] GPIOP_CFG_RST = 8'h00;
endpackage
`default_nettype wire

// ---- gpiop_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpiop_port
	import gpiop_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic [7:0]  pin_i,
	output logic      [7:0]  pin_o,
	output logic      [7:0]  pin_oe,
	output logic      [7:0]  pin_pu,
	output logic      [7:0]  pin_pd,
	output logic      [7:0]  pin_slew,
	input  wire logic [7:0]  alt_out,
	input  wire logic [7:0]  alt_oe,
	output logic      [7:0]  alt_in,
	input  wire logic        rtc_clk,
	input  wire logic [7:0]  ev_ch,
	output logic      [7:0]  pin_ev,
	output logic      [1:0]  port_int,
	output logic             irq,
	output logic             wake
);

	typedef struct packed {
		logic [7:0]      dir;
		logic [7:0]      out;
		logic [7:0]      mask0;
		logic [7:0]      mask1;
		logic [1:0]      flags;
		logic [1:0]      inten;
		logic [7:0]      multisel;
		logic [7:0][7:0] cfg;
		logic [2:0]      remap;
		logic [5:0]      outctl;
		logic            wake_en;
		logic [7:0]      sync1;
		logic [7:0]      sync2;
		logic [7:0]      prev;
		logic [7:0]      keeper;
		logic            rtc1;
		logic            rtc2;
		logic            clkdiv;
		logic            pready;
		logic [7:0]      prdata;
		logic            pslverr;
		logic [7:0]      pin_o;
		logic [7:0]      pin_oe;
		logic [7:0]      pin_pu;
		logic [7:0]      pin_pd;
		logic [7:0]      pin_slew;
		logic [7:0]      alt_in;
		logic [7:0]      pin_ev;
		logic [1:0]      port_int;
		logic            irq;
		logic            wake;
	} gpiop_state_s;

	gpiop_state_s s_q;
	gpiop_state_s s_d;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] gpiop_rmw(input logic [7:0] cur,
		input logic [7:0] wd, input logic [1:0] op);
		unique case (op)
			2'h0:    gpiop_rmw = wd;
			2'h1:    gpiop_rmw = cur | wd;
			2'h2:    gpiop_rmw = cur & ~wd;
			default: gpiop_rmw = cur ^ wd;
		endcase
	endfunction

	function automatic logic [7:0] gpiop_rot(input logic [7:0] v);
		gpiop_rot = {v[3:0], v[7:4]};
	endfunction

	// back=0: peripheral lanes to pins; back=1: pins to peripheral lanes
	function automatic logic [7:0] gpiop_map(input logic [7:0] v,
		input logic [2:0] r, input logic back);
		logic [7:0] res;
		res = v;
		for (int g = 0; g < 3; g++) begin
			if (r[g]) begin
				if (back)
					res = (res & ~GPIOP_GRP[g]) | (gpiop_rot(v) & GPIOP_GRP[g]);
				else
					res = (res & ~GPIOP_GRP[g]) | gpiop_rot(v & GPIOP_GRP[g]);
			end
		end
		gpiop_map = res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic       wr_en;
	logic       setup;
	logic [7:0] wd;
	logic [7:0] inv_v;
	logic [7:0] lv;
	logic [7:0] det;
	logic [7:0] a_o;
	logic [7:0] a_oe;
	logic       hit;
	logic [2:0] dm;
	logic       drv;
	logic       v;

	always_comb begin
		s_d    = s_q;
		wr_en  = psel & penable & s_q.pready & pwrite;
		setup  = psel & ~penable;
		wd     = pwdata[7:0];
		inv_v  = '0;
		det    = '0;
		hit    = 1'b1;
		dm     = GPIOP_DR_TOTEM;
		drv    = 1'b0;
		v      = 1'b0;

		// bus: one wait-free access phase
		s_d.pready  = setup;
		s_d.pslverr = 1'b0;
		if (setup) begin
			s_d.prdata = 8'h00;
			unique case (paddr)
				GPIOP_DIR:      s_d.prdata = s_q.dir;
				GPIOP_OUT:      s_d.prdata = s_q.out;
				GPIOP_IN:       s_d.prdata = s_q.sync2;
				GPIOP_MASK0:    s_d.prdata = s_q.mask0;
				GPIOP_MASK1:    s_d.prdata = s_q.mask1;
				GPIOP_FLAGS:    s_d.prdata = {6'h00, s_q.flags};
				GPIOP_INTEN:    s_d.prdata = {6'h00, s_q.inten};
				GPIOP_MULTISEL: s_d.prdata = s_q.multisel;
				GPIOP_REMAP:    s_d.prdata = {5'h00, s_q.remap};
				GPIOP_OUTCTL:   s_d.prdata = {2'h0, s_q.outctl};
				GPIOP_WAKECTL:  s_d.prdata = {7'h00, s_q.wake_en};
				GPIOP_DIRSET, GPIOP_DIRCLR, GPIOP_DIRTGL, GPIOP_OUTSET,
				GPIOP_OUTCLR, GPIOP_OUTTGL, GPIOP_FLAGCLR,
				GPIOP_MULTICFG: s_d.prdata = 8'h00;
				default: begin
					if (paddr >= GPIOP_PINCFG0 && paddr <= GPIOP_PINCFG7 &&
						paddr[1:0] == 2'h0)
						s_d.prdata = s_q.cfg[paddr[4:2]];
					else
						hit = 1'b0;
				end
			endcase
			s_d.pslverr = ~hit;
		end

		// register writes, one word per register, low byte used
		if (wr_en) begin
			unique case (paddr)
				GPIOP_DIR, GPIOP_DIRSET, GPIOP_DIRCLR, GPIOP_DIRTGL:
					s_d.dir = gpiop_rmw(s_q.dir, wd, paddr[3:2]);
				GPIOP_OUT, GPIOP_OUTSET, GPIOP_OUTCLR, GPIOP_OUTTGL:
					s_d.out = gpiop_rmw(s_q.out, wd, paddr[3:2]);
				GPIOP_MASK0:    s_d.mask0 = wd;
				GPIOP_MASK1:    s_d.mask1 = wd;
				GPIOP_INTEN:    s_d.inten = wd[1:0];
				GPIOP_MULTISEL: s_d.multisel = wd;
				GPIOP_REMAP:    s_d.remap = wd[2:0];
				GPIOP_OUTCTL:   s_d.outctl = wd[5:0];
				GPIOP_WAKECTL:  s_d.wake_en = wd[0];
				default: ;
			endcase
			for (int i = 0; i < GPIOP_PINS; i++) begin
				if (paddr == GPIOP_PINCFG0 + 12'(4 * i) ||
					(paddr == GPIOP_MULTICFG && s_q.multisel[i]))
					s_d.cfg[i] = wd;
			end
		end

		// input path: sync, invert, sense
		s_d.sync1 = pin_i;
		s_d.sync2 = s_q.sync1;
		s_d.rtc1  = rtc_clk;
		s_d.rtc2  = s_q.rtc1;
		for (int i = 0; i < GPIOP_PINS; i++)
			inv_v[i] = s_q.cfg[i][GPIOP_INV_BIT];
		lv = s_q.sync2 ^ inv_v;
		s_d.prev = lv;
		for (int i = 0; i < GPIOP_PINS; i++) begin
			unique case (s_q.cfg[i][GPIOP_SENSE_LSB +: 3])
				GPIOP_SN_BOTH: det[i] = lv[i] ^ s_q.prev[i];
				GPIOP_SN_RISE: det[i] = lv[i] & ~s_q.prev[i];
				GPIOP_SN_FALL: det[i] = ~lv[i] & s_q.prev[i];
				GPIOP_SN_LOW:  det[i] = ~lv[i];
				default:       det[i] = 1'b0;
			endcase
		end
		s_d.pin_ev = det;
		s_d.wake = s_q.wake_en & (|(det & (s_q.mask0 | s_q.mask1)));

		// sticky flags, set wins over clear
		s_d.flags[0] = (|(det & s_q.mask0)) |
			(s_q.flags[0] & ~(wr_en && paddr == GPIOP_FLAGCLR && wd[0]));
		s_d.flags[1] = (|(det & s_q.mask1)) |
			(s_q.flags[1] & ~(wr_en && paddr == GPIOP_FLAGCLR && wd[1]));
		s_d.port_int = s_q.flags & s_q.inten;
		s_d.irq = |(s_q.flags & s_q.inten);

		// output path
		a_o  = gpiop_map(alt_out, s_q.remap, 1'b0);
		a_oe = gpiop_map(alt_oe, s_q.remap, 1'b0);
		s_d.alt_in = gpiop_map(lv, s_q.remap, 1'b1);
		s_d.keeper = s_q.sync2;
		s_d.clkdiv = ~s_q.clkdiv;
		for (int i = 0; i < GPIOP_PINS; i++) begin
			dm  = s_q.cfg[i][GPIOP_DRIVE_LSB +: 3];
			drv = s_q.dir[i] | a_oe[i];
			v   = (a_oe[i] ? a_o[i] : s_q.out[i]) ^ inv_v[i];
			s_d.pin_slew[i] = s_q.cfg[i][GPIOP_SLEW_BIT];
			s_d.pin_pu[i] = 1'b0;
			s_d.pin_pd[i] = 1'b0;
			s_d.pin_o[i]  = v;
			s_d.pin_oe[i] = drv;
			unique case (dm)
				GPIOP_DR_KEEP: begin
					s_d.pin_pu[i] = ~drv & s_q.keeper[i];
					s_d.pin_pd[i] = ~drv & ~s_q.keeper[i];
				end
				GPIOP_DR_PULLDN: s_d.pin_pd[i] = ~drv;
				GPIOP_DR_PULLUP: s_d.pin_pu[i] = ~drv;
				GPIOP_DR_WOR, GPIOP_DR_WOR_PD: begin
					s_d.pin_o[i]  = 1'b1;
					s_d.pin_oe[i] = drv & v;
					s_d.pin_pd[i] = (dm == GPIOP_DR_WOR_PD);
				end
				GPIOP_DR_WAND, GPIOP_DR_WAND_PU: begin
					s_d.pin_o[i]  = 1'b0;
					s_d.pin_oe[i] = drv & ~v;
					s_d.pin_pu[i] = (dm == GPIOP_DR_WAND_PU);
				end
				default: ;
			endcase
		end
		if (s_q.outctl[GPIOP_CLKOUT_BIT]) begin
			s_d.pin_o[GPIOP_CLK_PIN]  = s_q.clkdiv;
			s_d.pin_oe[GPIOP_CLK_PIN] = 1'b1;
		end
		if (s_q.outctl[GPIOP_RTCOUT_BIT]) begin
			s_d.pin_o[GPIOP_RTC_PIN]  = s_q.rtc2;
			s_d.pin_oe[GPIOP_RTC_PIN] = 1'b1;
		end
		if (s_q.outctl[GPIOP_EVOUT_BIT]) begin
			s_d.pin_o[GPIOP_EV_PIN]  = ev_ch[s_q.outctl[GPIOP_EVSEL_LSB +: 3]];
			s_d.pin_oe[GPIOP_EV_PIN] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q     <= '0;
			s_q.cfg <= {GPIOP_PINS{GPIOP_CFG_RST}};
		end else begin
			s_q <= s_d;
		end
	end

	assign pready   = s_q.pready;
	assign prdata   = {24'h000000, s_q.prdata};
	assign pslverr  = s_q.pslverr;
	assign pin_o    = s_q.pin_o;
	assign pin_oe   = s_q.pin_oe;
	assign pin_pu   = s_q.pin_pu;
	assign pin_pd   = s_q.pin_pd;
	assign pin_slew = s_q.pin_slew;
	assign alt_in   = s_q.alt_in;
	assign pin_ev   = s_q.pin_ev;
	assign port_int = s_q.port_int;
	assign irq      = s_q.irq;
	assign wake     = s_q.wake;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_dirset_only: assert property (wr_en && paddr == GPIOP_DIRSET |=>
		s_q.dir == ($past(s_q.dir) | $past(pwdata[7:0])))
		else $error("dirset changed wrong bits");
	a_dirclr_others: assert property (wr_en && paddr == GPIOP_DIRCLR |=>
		(s_q.dir & ~$past(pwdata[7:0])) == ($past(s_q.dir) & ~$past(pwdata[7:0])))
		else $error("dirclr disturbed other pins");
	a_outtgl_flip: assert property (wr_en && paddr == GPIOP_OUTTGL |=>
		s_q.out == ($past(s_q.out) ^ $past(pwdata[7:0])))
		else $error("outtgl wrong");
	a_flag_holds: assert property (s_q.flags[0] &&
		!(wr_en && paddr == GPIOP_FLAGCLR) |=> s_q.flags[0])
		else $error("flag lost without clear");
	a_flag_sets: assert property (|(det & s_q.mask0) |=> s_q.flags[0])
		else $error("unmasked sense did not set flag");
	a_irq_level: assert property (##1 irq == |$past(s_q.flags & s_q.inten))
		else $error("irq does not follow enabled flags");
	a_multi_cfg: assert property (wr_en && paddr == GPIOP_MULTICFG &&
		s_q.multisel[3] |=> s_q.cfg[3] == $past(pwdata[7:0]))
		else $error("multi config missed selected pin");
	a_wand_low: assert property (s_q.cfg[0][GPIOP_DRIVE_LSB +: 3] ==
		GPIOP_DR_WAND ##1 pin_oe[0] |-> !pin_o[0])
		else $error("wired-and drove high");
	a_invert_sense: assert property (s_q.cfg[1][GPIOP_INV_BIT] &&
		s_q.cfg[1][GPIOP_SENSE_LSB +: 3] == GPIOP_SN_LOW && s_q.sync2[1]
		|=> pin_ev[1])
		else $error("inverted high pin not sensed low");
	a_bus_answer: assert property (psel && !penable |=> pready [*1] ##1 !pready)
		else $error("apb answer timing");

	c_flag_irq: cover property (s_q.flags[0] ##1 irq);
	c_flag_clear: cover property (s_q.flags[1] ##1 !s_q.flags[1]);
	c_keeper_hold: cover property (pin_pu[2] && !pin_oe[2]);
	c_remap_out: cover property (s_q.remap[0] && a_oe[0] ##1 pin_oe[4]);

endmodule // gpiop_port
`default_nettype wire

// ---- gpiop_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpiop_port_tb;
	import gpiop_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake, err, v;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [7:0]  pad, pin_o, pin_oe, pin_pu, pin_pd, pin_slew, alt_in, pin_ev;
	logic [7:0]  ext_v, ext_en, dir_m, out_m, cur, nv;
	logic [1:0]  port_int;
	logic        rtc, c7;
	logic [7:0]  evc, aout, aoe;
	int          n_mismatch, total_checks, k, op, p, md, iv, e;

	gpiop_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pin_i(pad), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_pu(pin_pu), .pin_pd(pin_pd), .pin_slew(pin_slew), .alt_out(aout),
		.alt_oe(aoe), .alt_in(alt_in), .rtc_clk(rtc), .ev_ch(evc), .pin_ev(pin_ev),
		.port_int(port_int), .irq(irq), .wake(wake));

	gpiop_board u_board (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.pin_pd(pin_pd), .ext_v(ext_v), .ext_en(ext_en), .pad(pad));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask

	function automatic int ev(int m, logic a, logic b);
		case (m)
			0: return int'(a != b);
			1: return int'(!a && b);
			2: return int'(a && !b);
			default: return int'(!a || !b);
		endcase
	endfunction

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		#400000;
		n_mismatch++;
		test_done();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_v = 8'hFF;
		ext_en = 8'h00;
		rtc = 1'b0;
		evc = 8'h00;
		aout = 8'h00;
		aoe = 8'h00;
		dir_m = 8'h00;
		out_m = 8'h00;
		void'($urandom(15016));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(GPIOP_DIR, 32'h0);
		rdchk(GPIOP_PINCFG7, 32'h0);
		rdchk(12'h050, 32'h0);
		chk(32'(err), 32'h1);
		rdchk(GPIOP_FLAGCLR, 32'h0);
		$display("test reset done");
		// random whole, set, clear and toggle writes
		for (k = 0; k < 24; k++) begin
			op = $urandom_range(7);
			d = $urandom_range(255);
			apb(12'(op * 4), 1'b1, d);
			cur = (op > 3) ? out_m : dir_m;
			case (op % 4)
				0: nv = d[7:0];
				1: nv = cur | d[7:0];
				2: nv = cur & ~d[7:0];
				default: nv = cur ^ d[7:0];
			endcase
			if (op > 3) out_m = nv;
			else dir_m = nv;
			rdchk(GPIOP_DIR, 32'(dir_m));
			rdchk(GPIOP_OUT, 32'(out_m));
			chk(32'(pin_oe), 32'(dir_m));
			chk(32'(pin_o & dir_m), 32'(out_m & dir_m));
		end
		$display("test rmw done");
		apb(GPIOP_DIRSET, 1'b1, 32'h01);
		for (k = 0; k < 4; k++) begin
			md = 4 + k / 2;
			v = k[0];
			apb(GPIOP_PINCFG0, 1'b1, 32'(8'h80 | (md << 3)));
			apb(GPIOP_OUT, 1'b1, 32'(v));
			@(posedge pclk);
			chk(32'(pin_oe[0]), 32'((md == 4) ? v : !v));
			chk(32'(pin_oe[0] ? pin_o[0] : v), 32'(v));
			chk(32'(pin_slew[0]), 32'h1);
		end
		$display("test drive done");
		aout <= 8'h01;
		aoe <= 8'h01;
		rtc <= 1'b1;
		evc <= 8'($urandom_range(255));
		p = $urandom_range(7);
		apb(GPIOP_REMAP, 1'b1, 32'h1);
		apb(GPIOP_OUTCTL, 1'b1, 32'(3'h7 | (p << 3)));
		repeat (3) @(posedge pclk);
		chk(32'({pin_oe[4], pin_o[4]}), 32'h3);
		chk(32'(pin_oe[7:5]), 32'h7);
		chk(32'({pin_o[6], pin_o[5]}), 32'({rtc, evc[p]}));
		c7 = pin_o[7];
		@(posedge pclk);
		chk(32'(c7 ^ pin_o[7]), 32'h1);
		apb(GPIOP_OUTCTL, 1'b1, 32'h0);
		apb(GPIOP_REMAP, 1'b1, 32'h0);
		aoe <= 8'h00;
		$display("test special done");
		apb(GPIOP_DIR, 1'b1, 32'h0);
		apb(GPIOP_INTEN, 1'b1, 32'h3);
		apb(GPIOP_WAKECTL, 1'b1, 32'h1);
		ext_en <= 8'hFF;
		for (k = 0; k < 8; k++) begin
			md = k % 4;
			iv = k / 4;
			p = $urandom_range(7);
			apb(GPIOP_MULTISEL, 1'b1, 32'hFF);
			apb(GPIOP_MULTICFG, 1'b1, 32'h18);
			apb(12'(GPIOP_PINCFG0 + 4 * p), 1'b1, 32'(md | 8'h18 | (iv << 6)));
			rdchk(12'(GPIOP_PINCFG0 + 4 * ((p + 1) % 8)), 32'h18);
			apb(GPIOP_MASK0, 1'b1, 32'(1 << p));
			apb(GPIOP_MASK1, 1'b1, 32'(~(1 << p) & 8'hFF));
			ext_v <= 8'hFF;
			repeat (6) @(posedge pclk);
			apb(GPIOP_FLAGCLR, 1'b1, 32'h3);
			rdchk(GPIOP_IN, 32'hFF);
			chk(32'(pin_pu[p]), 32'h1);
			ext_v[p] <= 1'b0;
			repeat (6) @(posedge pclk);
			e = ev(md, !iv[0], iv[0]);
			rdchk(GPIOP_FLAGS, 32'(e));
			chk(32'({port_int, irq}), 32'(e * 3));
			chk(32'(wake), 32'(md == 3 && iv == 0));
			chk(32'(pin_ev[p]), 32'(md == 3 && iv == 0));
			apb(GPIOP_FLAGCLR, 1'b1, 32'h3);
			ext_v[p] <= 1'b1;
			repeat (6) @(posedge pclk);
			e = ev(md, iv[0], !iv[0]);
			rdchk(GPIOP_FLAGS, 32'(e));
		end
		$display("test sense done");
		test_done();
	end
endmodule // gpiop_port_tb
`default_nettype wire
